// [include/usb_ctl_defines.vh]
/*
 USB OTG line, power and interrupt flag control: register offsets,
 field positions, reset values and timing counts.
 Assumes a 20 MHz pclk and a 32-bit APB register bus.
*/
`ifndef USB_CTL_DEFINES_VH
`define USB_CTL_DEFINES_VH

// Register byte offsets
`define OFS_OTG_LINE_CONTROL 12'h000
`define OFS_USB_POWER_CONTROL 12'h004
`define OFS_USB_INTERRUPT_FLAGS 12'h008
`define OFS_ERROR_ENABLE 12'h00c
`define OFS_STATUS_QUEUE 12'h010

// Line control fields
`define LC_DPLUS_PULLUP 7
`define LC_DMINUS_PULLUP 6
`define LC_DPLUS_PULLDOWN 5
`define LC_DMINUS_PULLDOWN 4
`define LC_BUS_POWER 3
`define LC_SW_PULL 2
`define LC_CHARGE 1
`define LC_DISCHARGE 0

// Power control fields
`define PC_ACTIVITY_PENDING 7
`define PC_SLEEP_GUARD 4
`define PC_MODULE_BUSY 3
`define PC_SUSPEND 1
`define PC_MODULE_ENABLE 0
`define PC_WRITE_MASK 8'h13

// Interrupt flag fields
`define IF_STALL 7
`define IF_ATTACH 6
`define IF_RESUME 5
`define IF_IDLE 4
`define IF_TOKEN_DONE 3
`define IF_FRAME_START 2
`define IF_ERROR_SUM 1
`define IF_BUS_RESET 0
`define IF_W1C_MASK 8'hfd

`define RESET_VALUE 8'h00

// Timing
`define CLK_HZ 20000000
`define RESUME_TIME_NS 2500
`define IDLE_TIME_US 3000
`define RESUME_CYCLES ((`RESUME_TIME_NS * 20 + 999) / 1000)
`define IDLE_CYCLES ((`IDLE_TIME_US * 20))
`define BUSY_DRAIN_CYCLES 4'h8

`endif

// [logic/line_state_timer.v]
/*
 Counts consecutive cycles that a qualifying line condition holds and
 pulses once when the count reaches its limit.
 Assumes cond is synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module line_state_timer #(
   parameter LIMIT = 50,
   parameter WIDTH = 17
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Condition and result
   input wire cond,
   output reg hit
);
   reg [WIDTH-1:0] count_q;

   // One pulse per unbroken stretch, so a held line never refires
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= {WIDTH{1'b0}};
         hit <= 1'b0;
      end else begin
         hit <= 1'b0;
         if (!cond) begin
            count_q <= {WIDTH{1'b0}};
         end else if (count_q < LIMIT[WIDTH-1:0]) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            if (count_q == LIMIT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
               hit <= 1'b1;
            end
         end
      end
   end
endmodule // line_state_timer
`default_nettype wire

// [logic/usb_ctl.v]
/*
 USB line control, power control and general interrupt flags, reached
 over APB. Assumes line status inputs and event strobes are synchronous
 to pclk and that events are one-cycle pulses.
*/
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "usb_ctl_defines.vh"

// What this block does
// RULE_01: Line control bit 7 enables the D+ pull-up.
// RULE_02: Line control bit 6 enables the D- pull-up.
// RULE_03: Line control bit 5 enables the D+ pull-down.
// RULE_04: Line control bit 4 enables the D- pull-down.
// RULE_05: Line control bit 3 requests VBUS power.
// RULE_06: Bit 2 selects software pulls, otherwise hardware drives them.
// RULE_07: Bit 1 charges VBUS through a pull-up.
// RULE_08: Bit 0 discharges VBUS through a pull-down.
// RULE_09: Bits 31 to 8 read zero and ignore writes.
// RULE_10: Activity pending reads one while detected activity awaits its flag.
// RULE_11: Sleep guard blocks sleep during activity or pending notification.
// RULE_12: Busy reads one while active or not yet ready to re-enable.
// RULE_13: Suspend gates the 48 MHz clock and idles the transceiver.
// RULE_14: Enable zero holds outputs inactive and releases pins; sleep_block is not gated by enable and still follows the sleep guard.
// RULE_15: Software avoids other registers while disabled and busy.
// RULE_16: Flags 7..2 and 0 are write-one-clear; bit 1 read-only.
// RULE_17: Clearing token done advances the completion status queue.
// RULE_18: Error summary rises only from enabled error conditions.
// RULE_19: Resume flag sets after K state lasting 2.5 us.
// RULE_20: Idle flag sets after 3 ms constant idle.
// RULE_21: A set event beats a same-cycle clear.
module usb_ctl #(
   parameter IDLE_CYCLES = `IDLE_CYCLES,
   parameter QDEPTH = 4,
   parameter QW = 8
) (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Hardware pull requests and line state
   input wire hw_dplus_pullup,
   input wire hw_dminus_pullup,
   input wire hw_dplus_pulldown,
   input wire hw_dminus_pulldown,
   input wire line_k_state,
   input wire line_idle,
   input wire bus_activity,
   input wire sleep_request,
   // Hardware events
   input wire stall_event,
   input wire attach_event,
   input wire token_done_event,
   input wire [QW-1:0] token_status,
   input wire frame_start_event,
   input wire bus_reset_event,
   input wire [7:0] error_events,
   // Transceiver and pad controls
   output reg dplus_pullup_en,
   output reg dminus_pullup_en,
   output reg dplus_pulldown_en,
   output reg dminus_pulldown_en,
   output reg bus_power_request,
   output reg bus_charge_en,
   output reg bus_discharge_en,
   output reg usb_clk_en,
   output reg xcvr_low_power,
   output reg pins_owned,
   output reg sleep_block,
   output reg activity_pending_o
);
   // Queue index width suits the default depth of four
   localparam QA = 2;
   localparam IDLE_W = 17;
   localparam RES_W = 6;

   reg [7:0] line_q;
   reg [7:0] power_q;
   reg [7:0] flags_q;
   reg [7:0] flags_d;
   reg [7:0] err_en_q;
   reg [7:0] err_flag_q;
   reg act_q;
   reg [3:0] drain_q;
   reg [QW-1:0] queue_q [0:QDEPTH-1];
   reg [QA-1:0] rd_q;
   reg [QA-1:0] wr_q;
   reg [QA:0] cnt_q;
   wire resume_hit;
   wire idle_hit;
   wire en;
   wire busy;
   wire wr_acc;
   wire rd_acc;
   wire clr_tok;
   wire push;
   wire [7:0] wbyte;
   wire [7:0] hw_set;
   wire [3:0] sw_pulls;
   wire [3:0] hw_pulls;
   wire [3:0] pull_sel;
   reg addr_ok;
   reg [31:0] rd_word;
   integer i;
   genvar g;

   line_state_timer #(.LIMIT(`RESUME_CYCLES), .WIDTH(RES_W)) u_resume (
      .pclk(pclk),
      .presetn(presetn),
      .cond(line_k_state),
      .hit(resume_hit)
   ); // RULE_19

   line_state_timer #(.LIMIT(IDLE_CYCLES), .WIDTH(IDLE_W)) u_idle (
      .pclk(pclk),
      .presetn(presetn),
      .cond(line_idle),
      .hit(idle_hit)
   ); // RULE_20

   assign en = power_q[`PC_MODULE_ENABLE];
   assign busy = en | (drain_q != 4'h0); // RULE_12
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & ~penable & ~pwrite;
   // Only the low byte is implemented; upper write data is dropped
   assign wbyte = pwdata[7:0]; // RULE_09
   assign clr_tok = wr_acc & (paddr == `OFS_USB_INTERRUPT_FLAGS) &
                    wbyte[`IF_TOKEN_DONE] & flags_q[`IF_TOKEN_DONE];
   assign push = en & token_done_event & (cnt_q != QDEPTH[QA:0]);

   assign hw_set = en ? {stall_event, attach_event, resume_hit, idle_hit,
                         1'b0, frame_start_event, 1'b0,
                         bus_reset_event} : 8'h00;

   // One selector per pull resistor: software bits or hardware requests
   assign sw_pulls[3] = line_q[`LC_DPLUS_PULLUP]; // RULE_01
   assign sw_pulls[2] = line_q[`LC_DMINUS_PULLUP]; // RULE_02
   assign sw_pulls[1] = line_q[`LC_DPLUS_PULLDOWN]; // RULE_03
   assign sw_pulls[0] = line_q[`LC_DMINUS_PULLDOWN]; // RULE_04
   assign hw_pulls = {hw_dplus_pullup, hw_dminus_pullup, hw_dplus_pulldown,
                      hw_dminus_pulldown};
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pull
         assign pull_sel[g] = line_q[`LC_SW_PULL] ? sw_pulls[g] :
                              hw_pulls[g]; // RULE_06
      end
   endgenerate

   // Flag update: clear first, then set so the event survives
   always @* begin
      flags_d = flags_q;
      if (wr_acc && paddr == `OFS_USB_INTERRUPT_FLAGS) begin
         flags_d = flags_q & ~(wbyte & `IF_W1C_MASK); // RULE_16
      end
      flags_d = flags_d | hw_set; // RULE_21
      // A push in the clearing cycle keeps the flag up
      flags_d[`IF_TOKEN_DONE] = push ||
         ((cnt_q != {(QA+1){1'b0}}) &&
          !(clr_tok && cnt_q == {{QA{1'b0}}, 1'b1})); // RULE_17
      flags_d[`IF_ERROR_SUM] = |(err_flag_q & err_en_q); // RULE_18
   end

   // Unmapped addresses answer with an error and read as zero
   always @* begin
      addr_ok = 1'b0;
      case (paddr)
         `OFS_OTG_LINE_CONTROL,
         `OFS_USB_POWER_CONTROL,
         `OFS_USB_INTERRUPT_FLAGS,
         `OFS_ERROR_ENABLE,
         `OFS_STATUS_QUEUE: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read mux; unimplemented bits stay zero
   always @* begin
      rd_word = 32'h00000000;
      case (paddr)
         `OFS_OTG_LINE_CONTROL: rd_word = {24'h000000, line_q};
         `OFS_USB_POWER_CONTROL: rd_word = {24'h000000, act_q, 2'b00,
            power_q[`PC_SLEEP_GUARD], busy, 1'b0,
            power_q[`PC_SUSPEND], en}; // RULE_10
         `OFS_USB_INTERRUPT_FLAGS: rd_word = {24'h000000, flags_q};
         `OFS_ERROR_ENABLE: rd_word = {24'h000000, err_en_q};
         `OFS_STATUS_QUEUE: rd_word = {{(32-QW){1'b0}}, queue_q[rd_q]};
         default: rd_word = 32'h00000000;
      endcase
   end

   // Every access completes in one cycle, so no wait-state logic
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
      end
   end

   // Read data is captured at setup and stands through the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_acc) begin
         prdata <= rd_word;
      end else if (psel && !penable) begin
         prdata <= 32'h00000000;
      end
   end

   // Writable registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q <= `RESET_VALUE;
         power_q <= `RESET_VALUE;
         err_en_q <= `RESET_VALUE;
      end else if (wr_acc) begin
         case (paddr)
            `OFS_OTG_LINE_CONTROL: line_q <= wbyte;
            `OFS_USB_POWER_CONTROL:
               power_q <= wbyte & `PC_WRITE_MASK;
            `OFS_ERROR_ENABLE: err_en_q <= wbyte;
            default: err_en_q <= err_en_q;
         endcase
      end
   end

   // Flags and sticky error conditions
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= `RESET_VALUE;
         err_flag_q <= `RESET_VALUE;
      end else begin
         flags_q <= flags_d;
         err_flag_q <= err_flag_q | (en ? error_events : 8'h00);
      end
   end

   // Token completion status queue
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= {QA{1'b0}};
         wr_q <= {QA{1'b0}};
         cnt_q <= {(QA+1){1'b0}};
         for (i = 0; i < QDEPTH; i = i + 1) begin
            queue_q[i] <= {QW{1'b0}};
         end
      end else begin
         if (push) begin
            queue_q[wr_q] <= token_status;
            wr_q <= wr_q + {{(QA-1){1'b0}}, 1'b1};
         end
         if (clr_tok) begin
            rd_q <= rd_q + {{(QA-1){1'b0}}, 1'b1}; // RULE_17
         end
         if (push && !clr_tok) begin
            cnt_q <= cnt_q + {{QA{1'b0}}, 1'b1};
         end else if (clr_tok && !push) begin
            cnt_q <= cnt_q - {{QA{1'b0}}, 1'b1};
         end
      end
   end

   // Pending while activity seen and the wake flag not yet raised
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 1'b0;
         activity_pending_o <= 1'b0;
      end else begin
         if (en && bus_activity && !flags_q[`IF_RESUME]) begin
            act_q <= 1'b1; // RULE_10
         end else if (!en || flags_q[`IF_RESUME]) begin
            act_q <= 1'b0;
         end
         activity_pending_o <= act_q;
      end
   end

   // Shutdown takes a few cycles, so busy lingers after disable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drain_q <= 4'h0;
      end else if (en) begin
         drain_q <= `BUSY_DRAIN_CYCLES;
      end else if (drain_q != 4'h0) begin
         drain_q <= drain_q - 4'h1; // RULE_12
      end
   end

   // Clock gate, transceiver power, pin ownership and sleep guard
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_clk_en <= 1'b0;
         xcvr_low_power <= 1'b1;
         pins_owned <= 1'b0;
         sleep_block <= 1'b0;
      end else begin
         // The guard only delays sleep; it never wakes a sleeping system
         sleep_block <= power_q[`PC_SLEEP_GUARD] & sleep_request &
                        (bus_activity | act_q); // RULE_11
         usb_clk_en <= en & ~power_q[`PC_SUSPEND]; // RULE_13
         xcvr_low_power <= ~en | power_q[`PC_SUSPEND]; // RULE_13
         pins_owned <= en; // RULE_14
      end
   end

   // Pad controls drop to inactive whenever the module is off
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dplus_pullup_en <= 1'b0;
         dminus_pullup_en <= 1'b0;
         dplus_pulldown_en <= 1'b0;
         dminus_pulldown_en <= 1'b0;
         bus_power_request <= 1'b0;
         bus_charge_en <= 1'b0;
         bus_discharge_en <= 1'b0;
      end else if (!en) begin
         // Released pads leave the lines to the board resistors
         dplus_pullup_en <= 1'b0; // RULE_14
         dminus_pullup_en <= 1'b0;
         dplus_pulldown_en <= 1'b0;
         dminus_pulldown_en <= 1'b0;
         bus_power_request <= 1'b0;
         bus_charge_en <= 1'b0;
         bus_discharge_en <= 1'b0;
      end else begin
         dplus_pullup_en <= pull_sel[3]; // RULE_01
         dminus_pullup_en <= pull_sel[2]; // RULE_02
         dplus_pulldown_en <= pull_sel[1]; // RULE_03
         dminus_pulldown_en <= pull_sel[0]; // RULE_04
         bus_power_request <= line_q[`LC_BUS_POWER]; // RULE_05
         bus_charge_en <= line_q[`LC_CHARGE]; // RULE_07
         bus_discharge_en <= line_q[`LC_DISCHARGE]; // RULE_08
      end
   end
endmodule // usb_ctl
`default_nettype wire

// [verif/usb_ctl_monitor.sv]
/* Assertions on the usb_ctl ports.
 Bound to usb_ctl; one clock domain, pclk. */
`timescale 1ns/100ps
`default_nettype none
module usb_ctl_monitor (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Line, power and sleep
   input wire logic bus_activity,
   input wire logic sleep_request,
   input wire logic dplus_pullup_en,
   input wire logic bus_power_request,
   input wire logic usb_clk_en,
   input wire logic xcvr_low_power,
   input wire logic pins_owned,
   input wire logic sleep_block,
   input wire logic activity_pending_o
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_read; pready && !pwrite; endsequence
   property p_answer; s_setup |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_unmap;
      pready && !pwrite && pslverr |-> prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped");
   property p_high; s_read |-> prdata[31:8] == 24'h0; endproperty
   a_high: assert property (p_high) else $error("high bits");
   property p_clk; usb_clk_en |-> pins_owned && !xcvr_low_power; endproperty
   a_clk: assert property (p_clk) else $error("clock gate");
   property p_off; !pins_owned |-> xcvr_low_power && !usb_clk_en; endproperty
   a_off: assert property (p_off) else $error("off state");
   // Pads may lag the enable by one cycle, hence the past term
   property p_pads;
      !pins_owned && !$past(pins_owned) |->
         !bus_power_request && !dplus_pullup_en;
   endproperty
   a_pads: assert property (p_pads) else $error("pads live");
   property p_sleep; sleep_block |-> $past(sleep_request); endproperty
   a_sleep: assert property (p_sleep) else $error("sleep");
   property p_act;
      // Two register stages lie between the line and the output
      $rose(activity_pending_o) |-> $past(bus_activity, 2);
   endproperty
   a_act: assert property (p_act) else $error("pending");
endmodule // usb_ctl_monitor
`default_nettype wire

// [verif/xcvr_model.sv]
/* Transceiver and cable model: line status levels.
 Assumes mode changes at the rising edge of pclk. */
`timescale 1ns/100ps
`default_nettype none
module xcvr_model (
   // Clock
   input wire logic pclk,
   // 0 quiet, 1 K state, 2 activity, 3 idle
   input wire logic [1:0] mode,
   // Line status
   output var logic line_k_state = 1'b0,
   output var logic line_idle = 1'b0,
   output var logic bus_activity = 1'b0
);
   // One register stage, like a real receiver's sampling
   always @(posedge pclk) begin
      line_k_state <= (mode == 2'd1);
      line_idle <= (mode == 2'd3);
      bus_activity <= (mode == 2'd2);
   end
endmodule // xcvr_model
`default_nettype wire

// [verif/test_usb_ctl.sv]
/* Self-checking bench for usb_ctl over APB.
 Assumes xcvr_model for line status; events come from here. */
`timescale 1ns/100ps
`default_nettype none
`include "usb_ctl_defines.vh"
module test_usb_ctl;
   localparam [11:0] A_LC = `OFS_OTG_LINE_CONTROL;
   localparam [11:0] A_PC = `OFS_USB_POWER_CONTROL;
   localparam [11:0] A_IF = `OFS_USB_INTERRUPT_FLAGS;
   logic pclk = 1'b0, presetn = 1'b0, sleep_request = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, erv;
   logic [3:0] hw = 4'h0;
   logic [4:0] ev = 5'h00;
   logic [7:0] token_status = 8'h00, error_events = 8'h00;
   logic [1:0] mode = 2'd0;
   logic line_k_state, line_idle, bus_activity;
   logic dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en;
   logic dminus_pulldown_en, bus_power_request, bus_charge_en;
   logic bus_discharge_en, usb_clk_en, xcvr_low_power, pins_owned;
   logic sleep_block, activity_pending_o;
   wire [6:0] pads = {dplus_pullup_en, dminus_pullup_en,
      dplus_pulldown_en, dminus_pulldown_en, bus_power_request,
      bus_charge_en, bus_discharge_en};
   integer err_total = 0, num_checks = 0;
   // Short idle count keeps the run brief
   usb_ctl #(.IDLE_CYCLES(20)) dut (.*,
      .hw_dplus_pullup(hw[3]), .hw_dminus_pullup(hw[2]),
      .hw_dplus_pulldown(hw[1]), .hw_dminus_pulldown(hw[0]),
      .stall_event(ev[4]), .attach_event(ev[3]),
      .token_done_event(ev[2]), .frame_start_event(ev[1]),
      .bus_reset_event(ev[0]));
   xcvr_model partner (.pclk(pclk), .mode(mode),
      .line_k_state(line_k_state), .line_idle(line_idle),
      .bus_activity(bus_activity));
   task chk(input logic [31:0] got, exp, input string nm);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("ERROR %s exp %h got %h", nm, exp, got);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold the request until pready is seen at a rising edge
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task st;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask
   task dwell(input logic [1:0] m, input integer n);
      @(posedge pclk);
      mode <= m;
      repeat (n) @(posedge pclk);
   endtask
   task pulse(input logic [4:0] e, input logic [7:0] s, input logic [7:0] r);
      ev <= e;
      token_status <= s;
      error_events <= r;
      @(posedge pclk);
      ev <= 5'h00;
      error_events <= 8'h00;
      @(posedge pclk);
   endtask
   task t_reset;
      @(negedge pclk);
      chk({pins_owned, xcvr_low_power, pads}, 9'h080, "rst out");
      bus(0, A_LC, 0);
      chk(rdv, 0, "line");
      bus(0, A_PC, 0);
      chk(rdv, 0, "power");
      bus(0, A_IF, 0);
      chk(rdv, 0, "flags");
   endtask
   task t_lines;
      bus(1, A_LC, 32'hffffffac);
      st;
      chk(pads, 0, "pads off");
      bus(1, A_PC, 32'h11);
      st;
      chk(pads, 7'h54, "sw pads");
      bus(0, A_LC, 0);
      chk(rdv, 32'hac, "line rd");
      hw <= 4'h9;
      bus(1, A_LC, 32'h53);
      st;
      chk(pads, 7'h4b, "hw pads");
      @(posedge pclk);
      hw <= 4'h6;
      st;
      chk(pads, 7'h33, "hw pads2");
   endtask
   task t_power;
      bus(1, A_PC, 32'hffffff9b);
      st;
      chk({usb_clk_en, xcvr_low_power}, 2'b01, "suspend");
      bus(0, A_PC, 0);
      chk(rdv, 32'h1b, "power rd");
      bus(1, A_PC, 32'h11);
      st;
      chk({usb_clk_en, xcvr_low_power}, 2'b10, "awake");
   endtask
   task t_wake;
      @(posedge pclk);
      sleep_request <= 1'b1;
      dwell(2'd2, 6);
      @(negedge pclk);
      chk(sleep_block, 1, "block");
      chk(activity_pending_o, 1, "pend out");
      bus(0, A_PC, 0);
      chk(rdv, 32'h99, "pending");
      dwell(2'd1, 60);
      dwell(2'd3, 10);
      bus(0, A_IF, 0);
      chk(rdv, 32'h20, "resume");
      @(negedge pclk);
      chk(sleep_block, 0, "unblock");
      chk(activity_pending_o, 0, "pend gone");
      bus(0, A_PC, 0);
      chk(rdv, 32'h19, "no pend");
      dwell(2'd3, 20);
      bus(0, A_IF, 0);
      chk(rdv, 32'h30, "idle");
      dwell(2'd0, 2);
      bus(1, A_IF, 32'h30);
      bus(0, A_IF, 0);
      chk(rdv, 0, "cleared");
   endtask
   task t_flags;
      bus(1, `OFS_ERROR_ENABLE, 0);
      pulse(5'h1f, 8'h5a, 8'h01);
      pulse(5'h04, 8'h3c, 8'h00);
      bus(0, A_IF, 0);
      chk(rdv, 32'hcd, "events");
      bus(1, `OFS_ERROR_ENABLE, 32'h01);
      bus(0, A_IF, 0);
      chk(rdv, 32'hcf, "err sum");
      bus(1, A_IF, 32'hff);
      bus(0, A_IF, 0);
      chk(rdv, 32'h0a, "queue");
      bus(0, `OFS_STATUS_QUEUE, 0);
      chk(rdv, 32'h3c, "head");
      // Stall lands on the access edge of the clearing write
      fork
         bus(1, A_IF, 32'h88);
         begin
            repeat (2) @(posedge pclk);
            ev <= 5'h10;
            @(posedge pclk);
            ev <= 5'h00;
         end
      join
      bus(0, A_IF, 0);
      chk(rdv, 32'h82, "set wins");
   endtask
   task t_off;
      bus(0, 12'h020, 0);
      chk(erv, 1, "slverr");
      chk(rdv, 0, "unmap rd");
      bus(1, A_PC, 0);
      bus(0, A_PC, 0);
      chk(rdv, 32'h08, "busy");
      st;
      chk({pins_owned, pads}, 0, "released");
      repeat (12) @(posedge pclk);
      bus(0, A_PC, 0);
      chk(rdv, 0, "ready");
   endtask
   initial forever #25 pclk = ~pclk;
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_lines;
      t_power;
      t_wake;
      t_flags;
      t_off;
      print_verdict;
   end
   initial begin
      repeat (4000) @(posedge pclk);
      err_total = err_total + 1;
      print_verdict;
   end
endmodule // test_usb_ctl
bind usb_ctl usb_ctl_monitor mon (.*);
`default_nettype wire
